//--- design/swr_pkg.sv
// package: constants, field layout and carrier types of the write recovery timing block
package swr_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_LAT  = 4'h4;
  localparam logic [3:0] OFS_REC  = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hC;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_BLF_LSB    = 0;
  localparam int CTRL_DBI_BIT    = 2;
  localparam int CTRL_PRE2_BIT   = 3;
  localparam int LAT_AL_LSB      = 0;
  localparam int LAT_CWL_LSB     = 8;
  localparam int REC_WR_LSB      = 0;
  localparam int REC_WRD_LSB     = 8;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_FORBID_BIT = 1;
  localparam int STAT_PEND_BIT   = 2;
  localparam int STAT_WCNT_LSB   = 8;
  localparam int STAT_PCNT_LSB   = 16;

  // ----------------------------------------------------------------
  // burst length field codes and burst shapes, in link clocks
  // ----------------------------------------------------------------
  localparam logic [1:0] BLF_FULL   = 2'h0;
  localparam logic [1:0] BLF_OTF    = 2'h1;
  localparam logic [1:0] BLF_CHOP   = 2'h2;
  localparam logic [7:0] SLOT_FULL  = 8'h04;
  localparam logic [7:0] SLOT_FIXED = 8'h02;
  localparam logic [7:0] DCLK_FULL  = 8'h04;
  localparam logic [7:0] DCLK_CHOP  = 8'h02;

  // ----------------------------------------------------------------
  // values after reset, the forbidden two-clock preamble latency and the zero read word
  // ----------------------------------------------------------------
  localparam logic [1:0]  RST_BLF  = 2'h0;
  localparam logic [4:0]  RST_AL   = 5'h00;
  localparam logic [4:0]  RST_CWL  = 5'h09;
  localparam logic [7:0]  RST_WR   = 8'h0C;
  localparam logic [7:0]  RST_WRD  = 8'h0D;
  localparam logic [4:0]  CWL_FORBID_2CK = 5'h09;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] blf;
    logic       data_bus_inversion;
    logic       pre2;
    logic [4:0] al;
    logic [4:0] column_write_latency;
    logic [7:0] wr;
    logic [7:0] wrd;
  } swr_cfg_s;

  typedef struct packed {
    logic       wr_valid;
    logic       auto_pre;
    logic [2:0] bank;
    logic       bsel;
  } swr_cmd_s;

  typedef enum logic [1:0] {L_IDLE, L_LAT, L_DATA, L_REC} swr_lst_e;

endpackage

//--- design/swr_write_timing.sv
// write latency, burst shape and write recovery tracking of the memory device
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// Overview of operation
// [RULE1] The controller waits total latency plus 4 clocks (full or otf chop) or 2 (fixed chop) plus recovery before precharge.
// [RULE2] Total write latency is additive latency plus column write latency, counted from the write command.
// [RULE3] The controller also keeps the activate-to-precharge interval before any precharge.
// [RULE4] Field 00, or field 01 with the burst select bit high, gives an eight-beat burst.
// [RULE5] Field 01 with the burst select bit low chops the write to four beats.
// [RULE6] Field 10 makes every write a fixed four-beat chop.
// [RULE7] Write recovery counts from the first rising edge after the last data beat.
// [RULE8] No precharge to the written bank before write recovery has passed after the last data.
// [RULE9] With data bus inversion on, the inversion recovery time replaces the normal one.
// [RULE10] In two-clock preamble mode column write latency of 9 is forbidden; the block only flags it in the status forbid bit and still runs writes.
// [RULE11] Auto precharge starts only after burst data and write recovery have completed.
// [RULE12] Idle command slots carry deselect or commands to other banks.
module swr_write_timing
  import swr_pkg::*;
(
  // system clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // memory link, on the link clock
  input  wire logic        ck_i,
  input  wire swr_cmd_s    cmd_i,
  output logic             data_window_o,
  output logic             precharge_o,
  output logic      [2:0]  precharge_bank_o
);

  // ----------------------------------------------------------------
  // state of both domains
  // ----------------------------------------------------------------
  typedef struct packed {
    swr_cfg_s    cfg;
    swr_cfg_s    sent;
    logic        req;
    logic        ack_s1;
    logic        ack_s2;
    logic [2:0]  wev_s;
    logic [2:0]  pev_s;
    logic        busy_s1;
    logic        busy_s2;
    logic [7:0]  wcnt;
    logic [15:0] pcnt;
    logic        ack;
    logic [31:0] dat;
  } swr_hst_s;

  typedef struct packed {
    logic       rst_s1;
    logic       rst_s2;
    logic       req_s1;
    logic       req_s2;
    logic       req_seen;
    swr_cfg_s   cfg;
    swr_lst_e   st;
    logic [7:0] cnt;
    logic [7:0] slot;
    logic [7:0] dclk;
    logic       auto_pre;
    logic [2:0] bank;
    logic       win;
    logic       pre;
    logic [2:0] pbank;
    logic       wev;
    logic       pev;
    logic       busy;
  } swr_lnk_s;

  swr_hst_s h_reg;
  swr_hst_s h_next;
  swr_lnk_s l_reg;
  swr_lnk_s l_next;
  logic     forbid;
  logic     pend;

  // ----------------------------------------------------------------
  // register image helpers
  // ----------------------------------------------------------------
  // byte-lane merge used for every writable word
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction

  // read view of a word; also the old value for byte-lane writes
  function automatic logic [31:0] rd(input logic [3:0] a, input swr_hst_s h,
                                     input logic fb, input logic pd);
    logic [31:0] r;
    r = RD_ZERO;
    case (a)
      OFS_CTRL:
      begin
        r[CTRL_BLF_LSB +: 2] = h.cfg.blf;
        r[CTRL_DBI_BIT]      = h.cfg.data_bus_inversion;
        r[CTRL_PRE2_BIT]     = h.cfg.pre2;
      end
      OFS_LAT:
      begin
        r[LAT_AL_LSB +: 5]  = h.cfg.al;
        r[LAT_CWL_LSB +: 5] = h.cfg.column_write_latency;
      end
      OFS_REC:
      begin
        r[REC_WR_LSB +: 8]  = h.cfg.wr;
        r[REC_WRD_LSB +: 8] = h.cfg.wrd;
      end
      OFS_STAT:
      begin
        r[STAT_BUSY_BIT]       = h.busy_s2;
        r[STAT_FORBID_BIT]     = fb;
        r[STAT_PEND_BIT]       = pd;
        r[STAT_WCNT_LSB +: 8]  = h.wcnt;
        r[STAT_PCNT_LSB +: 16] = h.pcnt;
      end
      default: r = RD_ZERO;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // system domain: bus slave, config hand-off, event counters
  // ----------------------------------------------------------------
  // [RULE10] forbidden preamble setting
  assign forbid = h_reg.cfg.pre2 && (h_reg.cfg.column_write_latency == CWL_FORBID_2CK);
  assign pend   = h_reg.req != h_reg.ack_s2;

  // single-cycle ack; the answer drops the cycle after it was given
  always_comb
  begin
    logic [31:0] img;
    img    = merge(rd(wb_adr_i, h_reg, forbid, pend), wb_dat_i, wb_sel_i);
    h_next = h_reg;
    h_next.ack    = wb_cyc_i && wb_stb_i && !h_reg.ack;
    // a newer config still waiting for its hand-off also reads as pending, so a
    // status poll can never slip through the one-cycle gap between two hand-offs
    h_next.dat    = rd(wb_adr_i, h_reg, forbid, pend || (h_reg.sent != h_reg.cfg));
    h_next.ack_s1 = l_reg.req_seen;
    h_next.ack_s2 = h_reg.ack_s1;
    h_next.wev_s  = {h_reg.wev_s[1:0], l_reg.wev};
    h_next.pev_s  = {h_reg.pev_s[1:0], l_reg.pev};
    h_next.busy_s1 = l_reg.busy;
    h_next.busy_s2 = h_reg.busy_s1;
    if (h_next.ack && wb_we_i)
    begin
      case (wb_adr_i)
        OFS_CTRL:
        begin
          h_next.cfg.blf  = img[CTRL_BLF_LSB +: 2];
          h_next.cfg.data_bus_inversion  = img[CTRL_DBI_BIT];
          h_next.cfg.pre2 = img[CTRL_PRE2_BIT];
        end
        OFS_LAT:
        begin
          h_next.cfg.al  = img[LAT_AL_LSB +: 5];
          h_next.cfg.column_write_latency = img[LAT_CWL_LSB +: 5];
        end
        OFS_REC:
        begin
          h_next.cfg.wr  = img[REC_WR_LSB +: 8];
          h_next.cfg.wrd = img[REC_WRD_LSB +: 8];
        end
        default: h_next.cfg = h_reg.cfg;
      endcase
    end
    // snapshot is held still until the link side has echoed the toggle
    if (!pend && (h_reg.sent != h_reg.cfg))
    begin
      h_next.sent = h_reg.cfg;
      h_next.req  = !h_reg.req;
    end
    if (h_reg.wev_s[2] != h_reg.wev_s[1])
      h_next.wcnt = h_reg.wcnt + 8'h01;
    if (h_reg.pev_s[2] != h_reg.pev_s[1])
      h_next.pcnt = h_reg.pcnt + 16'h0001;
    if (rst_i)
    begin
      h_next = '0;
      h_next.cfg = '{blf: RST_BLF, data_bus_inversion: 1'b0, pre2: 1'b0, al: RST_AL, column_write_latency: RST_CWL,
                     wr: RST_WR, wrd: RST_WRD};
      h_next.sent = h_next.cfg;
    end
  end

  // system state register
  always_ff @(posedge clk_i)
    h_reg <= h_next;

  assign wb_ack_o = h_reg.ack;
  assign wb_dat_o = h_reg.dat;

  // ----------------------------------------------------------------
  // link domain: latency, burst and recovery sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    l_next = l_reg;
    l_next.rst_s1 = rst_i;
    l_next.rst_s2 = l_reg.rst_s1;
    l_next.req_s1 = h_reg.req;
    l_next.req_s2 = l_reg.req_s1;
    l_next.pre    = 1'b0;
    // config words are only taken once the toggle has settled
    if (l_reg.req_s2 != l_reg.req_seen)
    begin
      l_next.cfg      = h_reg.sent;
      l_next.req_seen = l_reg.req_s2;
    end
    case (l_reg.st)
      L_IDLE:
      begin
        // [RULE12] only writes are acted on, all else passes
        if (cmd_i.wr_valid)
        begin
          // [RULE2] latency is additive plus column latency
          l_next.cnt      = 8'({3'b000, l_reg.cfg.al} + {3'b000, l_reg.cfg.column_write_latency}) - 8'h01;
          l_next.st       = L_LAT;
          l_next.auto_pre = cmd_i.auto_pre;
          l_next.bank     = cmd_i.bank;
          l_next.wev      = !l_reg.wev;
          // [RULE4] eight beats on full field or otf select high
          l_next.slot = SLOT_FULL;
          l_next.dclk = DCLK_FULL;
          // [RULE5] otf chop keeps a four-clock slot
          if (l_reg.cfg.blf == BLF_OTF && !cmd_i.bsel)
            l_next.dclk = DCLK_CHOP;
          // [RULE6] fixed chop shortens the slot too
          if (l_reg.cfg.blf == BLF_CHOP)
          begin
            l_next.slot = SLOT_FIXED;
            l_next.dclk = DCLK_CHOP;
          end
        end
      end
      L_LAT:
      begin
        l_next.cnt = l_reg.cnt - 8'h01;
        if (l_reg.cnt == 8'h00)
        begin
          l_next.st  = L_DATA;
          l_next.cnt = l_reg.slot - 8'h01;
        end
      end
      L_DATA:
      begin
        l_next.cnt = l_reg.cnt - 8'h01;
        if (l_reg.cnt == 8'h00)
        begin
          // [RULE7] recovery starts on the edge after the last clock of the slot, two clocks after the last beat for otf chop
          l_next.st = L_REC;
          // [RULE9] inversion recovery replaces normal recovery
          l_next.cnt = (l_reg.cfg.data_bus_inversion ? l_reg.cfg.wrd : l_reg.cfg.wr) - 8'h01;
        end
      end
      L_REC:
      begin
        l_next.cnt = l_reg.cnt - 8'h01;
        if (l_reg.cnt == 8'h00)
        begin
          // [RULE11] auto precharge once data and recovery are done
          l_next.st = L_IDLE;
          if (l_reg.auto_pre)
          begin
            l_next.pre   = 1'b1;
            l_next.pbank = l_reg.bank;
            l_next.pev   = !l_reg.pev;
          end
        end
      end
      default: l_next.st = L_IDLE;
    endcase
    // [RULE4] window covers only the beats that carry data
    l_next.win  = (l_next.st == L_DATA) && (l_next.cnt >= l_next.slot - l_next.dclk);
    l_next.busy = l_next.st != L_IDLE;
    // [RULE3] activate spacing is not rechecked here; the controller owns it
    if (l_reg.rst_s2)
    begin
      l_next = '0;
      l_next.rst_s1 = rst_i;
      l_next.rst_s2 = l_reg.rst_s1;
      l_next.st  = L_IDLE;
      l_next.cfg = '{blf: RST_BLF, data_bus_inversion: 1'b0, pre2: 1'b0, al: RST_AL, column_write_latency: RST_CWL,
                     wr: RST_WR, wrd: RST_WRD};
    end
  end

  // link state register
  always_ff @(posedge ck_i)
    l_reg <= l_next;

  assign data_window_o    = l_reg.win;
  assign precharge_o      = l_reg.pre;
  assign precharge_bank_o = l_reg.pbank;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_take;
    l_reg.st == L_IDLE && cmd_i.wr_valid;
  endsequence

  a_bus_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  a_latency_sum: assert property (@(posedge ck_i) disable iff (l_reg.rst_s2) // [RULE2]
    s_take |=> l_reg.st == L_LAT &&
      l_reg.cnt == 8'({3'b000, $past(l_reg.cfg.al)} + {3'b000, $past(l_reg.cfg.column_write_latency)}) - 8'h01)
    else $error("latency not additive plus column latency");
  a_full_burst: assert property (@(posedge ck_i) disable iff (l_reg.rst_s2) // [RULE4]
    s_take ##0 (l_reg.cfg.blf == BLF_FULL || (l_reg.cfg.blf == BLF_OTF && cmd_i.bsel))
    |=> l_reg.dclk == DCLK_FULL && l_reg.slot == SLOT_FULL) else $error("full burst shape");
  a_otf_chop: assert property (@(posedge ck_i) disable iff (l_reg.rst_s2) // [RULE5]
    s_take ##0 (l_reg.cfg.blf == BLF_OTF && !cmd_i.bsel)
    |=> l_reg.dclk == DCLK_CHOP && l_reg.slot == SLOT_FULL) else $error("otf chop shape");
  a_fixed_chop: assert property (@(posedge ck_i) disable iff (l_reg.rst_s2) // [RULE6]
    s_take ##0 l_reg.cfg.blf == BLF_CHOP
    |=> l_reg.dclk == DCLK_CHOP && l_reg.slot == SLOT_FIXED) else $error("fixed chop shape");
  a_window_eight: assert property (@(posedge ck_i) disable iff (l_reg.rst_s2) // [RULE4]
    $rose(data_window_o) && l_reg.dclk == DCLK_FULL |-> data_window_o[*4] ##1 !data_window_o)
    else $error("eight-beat window length");
  a_dbi_recovery: assert property (@(posedge ck_i) disable iff (l_reg.rst_s2) // [RULE9]
    l_reg.st == L_DATA && l_reg.cnt == 8'h00 && l_reg.cfg.data_bus_inversion
    |=> l_reg.st == L_REC && l_reg.cnt == $past(l_reg.cfg.wrd) - 8'h01)
    else $error("inversion recovery not used");
  a_pre_after_rec: assert property (@(posedge ck_i) disable iff (l_reg.rst_s2) // [RULE11]
    precharge_o |-> $past(l_reg.st) == L_REC && $past(l_reg.cnt) == 8'h00 && !data_window_o)
    else $error("precharge before recovery end");

endmodule

//--- tb/sdram_write_recovery_timing_test.sv
// testbench: register access, write timing per burst mode and status counters
`timescale 1ns/10ps
module sdram_write_recovery_timing_test;
  import swr_pkg::*;
  typedef struct packed {
    logic [1:0] blf; logic data_bus_inversion; logic pre2; logic [4:0] al; logic [4:0] column_write_latency;
    logic [7:0] wr; logic [7:0] wrd; logic bsel; logic ap; logic [2:0] bank; logic extra;
  } swr_row_s;
  logic clk_i, ck_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, go, m_bsel, m_auto, m_extra;
  logic precharge_o, data_window_o, done, pend;
  logic [3:0]  wb_adr, wb_sel;
  logic [31:0] wb_dat, wb_dat_o, q;
  logic [2:0]  m_bank, precharge_bank_o, m_pbank;
  logic [7:0]  m_lat, m_dlen, m_pre, wl, s, d, r;
  swr_cmd_s    cmd;
  swr_row_s    rows [6];
  int          fails, compares, n, npre;
  // ----------------------------------------------------------------
  // clocks, device and controller model
  // ----------------------------------------------------------------
  initial begin clk_i = 0; forever #25 clk_i = ~clk_i; end
  initial begin ck_i = 0; #7; forever #16 ck_i = ~ck_i; end
  swr_write_timing u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ck_i(ck_i), .cmd_i(cmd),
    .data_window_o(data_window_o), .precharge_o(precharge_o),
    .precharge_bank_o(precharge_bank_o));
  swr_ctrl_model u_ctrl (.ck_i(ck_i), .rst_i(rst_i), .go_i(go), .bsel_i(m_bsel),
    .auto_i(m_auto), .extra_i(m_extra), .bank_i(m_bank), .data_window_i(data_window_o),
    .precharge_i(precharge_o), .pbank_i(precharge_bank_o), .cmd_o(cmd), .done_o(done),
    .lat_o(m_lat), .dlen_o(m_dlen), .pre_o(m_pre), .bank_o(m_pbank));
  // classic wishbone cycle; ack and data are the values sampled at the edge
  task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [31:0] dv);
    int k;
    @(posedge clk_i);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= w; wb_adr <= a; wb_dat <= dv; wb_sel <= 4'hF;
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) fails++;
    q = wb_dat_o;
    wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin #200000; fails++; conclude(); end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_i = 1; wb_cyc = 0; wb_stb = 0; wb_we = 0; wb_adr = 0; wb_sel = 0; wb_dat = 0;
    go = 0; m_bsel = 0; m_auto = 0; m_extra = 0; m_bank = 0; fails = 0; compares = 0; npre = 0;
    rows = '{'{2'h0, 1'b0, 1'b0, 5'd0, 5'd9, 8'd12, 8'd13, 1'b0, 1'b1, 3'd3, 1'b0},
             '{2'h1, 1'b0, 1'b0, 5'd0, 5'd9, 8'd12, 8'd13, 1'b0, 1'b1, 3'd5, 1'b1},
             '{2'h1, 1'b0, 1'b0, 5'd2, 5'd10, 8'd5, 8'd7, 1'b1, 1'b1, 3'd6, 1'b0},
             '{2'h2, 1'b0, 1'b1, 5'd0, 5'd10, 8'd12, 8'd13, 1'b1, 1'b1, 3'd2, 1'b0},
             '{2'h0, 1'b1, 1'b1, 5'd3, 5'd9, 8'd6, 8'd15, 1'b0, 1'b1, 3'd7, 1'b0},
             '{2'h2, 1'b1, 1'b0, 5'd1, 5'd9, 8'd4, 8'd8, 1'b0, 1'b0, 3'd1, 1'b0}};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    // values after reset, then an unmapped word
    wb_xfer(1'b0, OFS_CTRL, 0); check(q, RD_ZERO);
    wb_xfer(1'b0, OFS_LAT, 0); check(q, {19'h0, RST_CWL, 3'h0, RST_AL});
    wb_xfer(1'b0, OFS_REC, 0); check(q, {16'h0, RST_WRD, RST_WR});
    wb_xfer(1'b0, OFS_STAT, 0); check(q, RD_ZERO);
    wb_xfer(1'b0, 4'h2, 0); check(q, RD_ZERO);
    for (int i = 0; i < 6; i++)
    begin
      wb_xfer(1'b1, OFS_CTRL, {28'h0, rows[i].pre2, rows[i].data_bus_inversion, rows[i].blf});
      wb_xfer(1'b1, OFS_LAT, {19'h0, rows[i].column_write_latency, 3'h0, rows[i].al});
      wb_xfer(1'b1, OFS_REC, {16'h0, rows[i].wrd, rows[i].wr});
      n = 0;
      do begin wb_xfer(1'b0, OFS_STAT, 0); pend = q[STAT_PEND_BIT]; n++; end
      while (pend !== 1'b0 && n < 50);
      if (pend !== 1'b0) fails++;
      @(posedge clk_i);
      m_bsel <= rows[i].bsel; m_auto <= rows[i].ap; m_bank <= rows[i].bank;
      m_extra <= rows[i].extra; go <= ~go;
      repeat (8) @(posedge clk_i);
      wb_xfer(1'b0, OFS_STAT, 0);
      check({31'h0, q[STAT_BUSY_BIT]}, 32'h0000_0001);
      n = 0;
      do begin @(posedge clk_i); n++; end while (done === go && n < 400);
      do begin @(posedge clk_i); n++; end while (done !== go && n < 400);
      if (n >= 400) fails++;
      // let the event counters finish crossing into the bus clock
      repeat (4) @(posedge clk_i);
      wl = 8'(rows[i].al) + 8'(rows[i].column_write_latency);
      s = (rows[i].blf == BLF_CHOP) ? SLOT_FIXED : SLOT_FULL;
      d = (rows[i].blf == BLF_CHOP || (rows[i].blf == BLF_OTF && !rows[i].bsel)) ?
          DCLK_CHOP : DCLK_FULL;
      r = rows[i].data_bus_inversion ? rows[i].wrd : rows[i].wr;
      check({24'h0, m_lat}, {24'h0, wl + 8'h01});
      check({24'h0, m_dlen}, {24'h0, d});
      check({24'h0, m_pre}, {24'h0, rows[i].ap ? wl + s + r + 8'h01 : 8'hFF});
      if (rows[i].ap)
      begin
        npre++;
        check({29'h0, m_pbank}, {29'h0, rows[i].bank});
      end
      wb_xfer(1'b0, OFS_STAT, 0);
      check(q, {16'(npre), 8'(i + 1), 6'h0,
                rows[i].pre2 && rows[i].column_write_latency == CWL_FORBID_2CK, 1'b0});
    end
    conclude();
  end
endmodule

//--- tb/swr_ctrl_model.sv
// memory controller model: issues write commands on the link clock and times the answers
`timescale 1ns/10ps
module swr_ctrl_model
  import swr_pkg::*;
(
  // link clock, reset and test control
  input  wire logic       ck_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic       bsel_i,
  input  wire logic       auto_i,
  input  wire logic       extra_i,
  input  wire logic [2:0] bank_i,
  // device answers
  input  wire logic       data_window_i,
  input  wire logic       precharge_i,
  input  wire logic [2:0] pbank_i,
  // commands and measurements
  output swr_cmd_s        cmd_o,
  output logic            done_o,
  output logic      [7:0] lat_o,
  output logic      [7:0] dlen_o,
  output logic      [7:0] pre_o,
  output logic      [2:0] bank_o
);
  logic [2:0] go_sync;
  logic [3:0] pat;
  logic [7:0] cnt;
  logic       run;
  logic       seen;
  // no explicit precharge
  // the model never precharges on its own, so every spacing to a precharge is kept
  always_ff @(posedge ck_i)
  begin
    if (rst_i)
    begin
      go_sync <= '0;
      pat <= '0;
      run <= 1'b0;
      seen <= 1'b0;
      cmd_o <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      go_sync <= {go_sync[1:0], go_i};
      pat <= pat + 4'h1;
      // deselect between commands
      // idle slots carry a changing pattern so stale fields never look valid
      cmd_o <= '{1'b0, pat[0], pat[3:1], ~pat[0]};
      if (cmd_o.wr_valid && !run)
      begin
        run <= 1'b1;
        cnt <= 8'h01;  // command edge is cycle zero, the first sample after it cycle one
        seen <= 1'b0;
        dlen_o <= 8'h00;
        pre_o <= 8'hFF;
      end
      else if (run)
      begin
        cnt <= cnt + 8'h01;
        if (data_window_i)
        begin
          dlen_o <= dlen_o + 8'h01;
          if (!seen)
            lat_o <= cnt;
          seen <= 1'b1;
        end
        // a write while busy must be dropped by the device
        if (extra_i && cnt == 8'h03)
          cmd_o <= '{1'b1, auto_i, bank_i, bsel_i};
        if (precharge_i || cnt == 8'd80)
        begin
          run <= 1'b0;
          done_o <= ~done_o;
          if (precharge_i)
          begin
            pre_o <= cnt;
            bank_o <= pbank_i;
          end
        end
      end
      else if (go_sync[2] != go_sync[1])
        cmd_o <= '{1'b1, auto_i, bank_i, bsel_i};
    end
  end
endmodule
